//--- rtl/port_a_pin_function_mux.v
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "port_a_map.vh"
module port_a_pin_function_mux #(
  parameter PINS = 7
) (
  clock,
  resetn,
  wbCyc,
  wbStb,
  wbWe,
  wbAdr,
  wbSel,
  wbDatW,
  wbDatR,
  wbAck,
  opMode,
  busCtlEnable,
  waitEnable,
  busAckOutN,
  busReqInN,
  waitInN,
  ocEnable,
  ocLevel,
  serialTxOut,
  serialRxIn,
  serialClockOut,
  serialClockOe,
  serialClockIn,
  pwmOut,
  pageAddr,
  pinIn,
  pinOut,
  pinOe
);
  input wire clock;
  input wire resetn;
  input wire wbCyc;
  input wire wbStb;
  input wire wbWe;
  input wire [17:0] wbAdr;
  input wire [3:0] wbSel;
  input wire [31:0] wbDatW;
  output wire [31:0] wbDatR;
  output wire wbAck;
  input wire [2:0] opMode;
  input wire busCtlEnable;
  input wire waitEnable;
  input wire busAckOutN;
  output wire busReqInN;
  output wire waitInN;
  input wire [5:0] ocEnable;
  input wire [5:0] ocLevel;
  input wire serialTxOut;
  output wire serialRxIn;
  input wire serialClockOut;
  input wire serialClockOe;
  output wire serialClockIn;
  input wire [2:0] pwmOut;
  input wire [3:0] pageAddr;
  input wire [PINS-1:0] pinIn;
  output wire [PINS-1:0] pinOut;
  output wire [PINS-1:0] pinOe;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  reg [6:0] dir_ff;
  reg [6:0] data_ff;
  reg [6:0] ctrl_ff;
  reg ack_ff;
  reg [7:0] rdData_ff;
  reg [7:0] nxt_rdData;
  wire [PINS-1:0] readBits;
  wire request;
  wire hitDir;
  wire hitData;
  wire hitCtrl;
  wire wrLane;
  // Reset values kept at full width; only the stored bits are sliced off
  localparam [7:0] DIR_RST = `PA_DIR_RESET;
  localparam [7:0] DATA_RST = `PA_DATA_RESET;
  localparam [7:0] CTRL_RST = `PA_CTRL_RESET;

  // One access per request, ack drops the cycle after
  assign request = wbCyc & wbStb & ~ack_ff;
  assign hitDir = (wbAdr[17:2] == `PA_DIR_IDX);
  assign hitData = (wbAdr[17:2] == `PA_DATA_IDX);
  assign hitCtrl = (wbAdr[17:2] == `PA_CTRL_IDX);
  assign wrLane = request & wbWe & wbSel[0];

  // Read mux; unmapped addresses still ack and read zero
  always @* begin
    nxt_rdData = 8'h00;
    if (hitDir) begin
      nxt_rdData = `PA_DIR_READ;
    end else if (hitData) begin
      nxt_rdData = `PA_DATA_FIXED | {1'b0, readBits};
    end else if (hitCtrl) begin
      nxt_rdData = `PA_CTRL_FIXED | {1'b0, ctrl_ff};
    end
  end

  // Writes land on the edge that gives ack
  always @(posedge clock) begin
    if (!resetn) begin
      dir_ff <= DIR_RST[6:0];
      data_ff <= DATA_RST[6:0];
      ctrl_ff <= CTRL_RST[6:0] & 7'h6F;
      ack_ff <= 1'b0;
      rdData_ff <= 8'h00;
    end else begin
      ack_ff <= request;
      if (request) begin
        rdData_ff <= nxt_rdData;
      end
      if (wrLane && hitDir) begin
        dir_ff <= wbDatW[6:0];
      end
      // Always stored; whether it reaches a pin is the slice's business
      if (wrLane && hitData) begin
        data_ff <= wbDatW[6:0];
      end
      // Bit 4 is read-only and stays clear in storage
      if (wrLane && hitCtrl) begin
        ctrl_ff <= wbDatW[6:0] & 7'h6F;
      end
    end
  end

  assign wbAck = ack_ff;
  assign wbDatR = {24'h000000, rdData_ff};

  ////////////////////////////////////////////////////////////////////////////
  // Mode and enable decode

  wire txEn;
  wire rxEn;
  wire [3:0] lowEn;
  wire modeBus;
  wire serialFirst;
  wire pageForced;
  wire pageByDir;
  wire busOn;

  assign txEn = ctrl_ff[`PA_TX_EN_BIT];
  assign rxEn = ctrl_ff[`PA_RX_EN_BIT];
  assign lowEn = {ctrl_ff[`PA_SCK_EN_BIT], ctrl_ff[`PA_PWM3_EN_BIT],
                  ctrl_ff[`PA_PWM2_EN_BIT], ctrl_ff[`PA_PWM1_EN_BIT]};
  // Bus control exists in modes 1 to 6 only
  assign modeBus = (opMode >= `PA_MODE1) && (opMode <= `PA_MODE6);
  assign serialFirst = (opMode == `PA_MODE3) || (opMode == `PA_MODE5);
  assign pageForced = serialFirst;
  assign pageByDir = (opMode == `PA_MODE4);
  assign busOn = modeBus & busCtlEnable;

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin function selection, purely combinational

  reg [PINS-1:0] altUse;
  reg [PINS-1:0] altOe;
  reg [PINS-1:0] altOut;
  reg [PINS-1:0] altRead;
  reg [5:0] ocSel;
  reg [3:0] lowOc;
  reg busAckSel;
  reg busReqSel;
  reg waitSel;
  reg rxSel;
  reg sckSel;
  integer i;

  // Low-pin compare channels: pin0..3 carry timer bits 0..3
  always @* begin
    lowOc = ocEnable[3:0];
    ocSel = 6'h00;
    busAckSel = 1'b0;
    busReqSel = 1'b0;
    waitSel = 1'b0;
    rxSel = 1'b0;
    sckSel = 1'b0;
    altUse = {PINS{1'b0}};
    altOe = {PINS{1'b0}};
    altOut = {PINS{1'b0}};
    altRead = {PINS{1'b0}};

    // Pin 6: transmit first in modes 3 and 5, then acknowledge, transmit, compare, general
    if (serialFirst && txEn) begin
      altUse[6] = 1'b1;
      altOe[6] = 1'b1;
      altOut[6] = serialTxOut;
      altRead[6] = pinIn[6];
    end else if (busOn) begin
      busAckSel = 1'b1;
      altUse[6] = 1'b1;
      altOe[6] = 1'b1;
      altOut[6] = busAckOutN;
      altRead[6] = pinIn[6];
    end else if (txEn) begin
      altUse[6] = 1'b1;
      altOe[6] = 1'b1;
      altOut[6] = serialTxOut;
      altRead[6] = pinIn[6];
    end else if (ocEnable[5]) begin
      ocSel[5] = 1'b1;
      altUse[6] = 1'b1;
      altOe[6] = 1'b1;
      altOut[6] = ocLevel[5];
      altRead[6] = ocLevel[5];
    end

    // Pin 5: receive first in modes 3 and 5, then request, receive, compare, general
    if (serialFirst && rxEn) begin
      rxSel = 1'b1;
      altUse[5] = 1'b1;
      altRead[5] = pinIn[5];
    end else if (busOn) begin
      busReqSel = 1'b1;
      altUse[5] = 1'b1;
      altRead[5] = pinIn[5];
    end else if (rxEn) begin
      rxSel = 1'b1;
      altUse[5] = 1'b1;
      altRead[5] = pinIn[5];
    end else if (ocEnable[4]) begin
      ocSel[4] = 1'b1;
      altUse[5] = 1'b1;
      altOe[5] = 1'b1;
      altOut[5] = ocLevel[4];
      altRead[5] = ocLevel[4];
    end

    // Pin 4: wait input or general
    if (modeBus && waitEnable) begin
      waitSel = 1'b1;
      altUse[4] = 1'b1;
      altRead[4] = pinIn[4];
    end

    // Pins 3..0: clock or PWM, then page address or compare
    for (i = 0; i < 4; i = i + 1) begin
      if (lowEn[i]) begin
        altUse[i] = 1'b1;
        if (i == 3) begin
          sckSel = 1'b1;
          altOe[i] = serialClockOe;
          altOut[i] = serialClockOut;
        end else begin
          altOe[i] = 1'b1;
          altOut[i] = pwmOut[i];
        end
        altRead[i] = pinIn[i];
      end else if (pageForced || (pageByDir && dir_ff[i])) begin
        altUse[i] = 1'b1;
        altOe[i] = 1'b1;
        altOut[i] = pageAddr[i];
        altRead[i] = pinIn[i];
      end else if (pageByDir) begin
        // Mode 4 low pins never act as general output
        altUse[i] = 1'b1;
        altRead[i] = pinIn[i];
      end else if (lowOc[i]) begin
        ocSel[i] = 1'b1;
        altUse[i] = 1'b1;
        altOe[i] = 1'b1;
        altOut[i] = ocLevel[i];
        altRead[i] = ocLevel[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin slices

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : gPin
      port_pin_slice uSlice (
        .altUse(altUse[g]),
        .altOe(altOe[g]),
        .altOut(altOut[g]),
        .altRead(altRead[g]),
        .dirBit(dir_ff[g]),
        .dataBit(data_ff[g]),
        .pinIn(pinIn[g]),
        .pinOut(pinOut[g]),
        .pinOe(pinOe[g]),
        .readBit(readBits[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels handed to peripherals; idle levels when not routed

  assign busReqInN = busReqSel ? pinIn[5] : 1'b1;
  assign waitInN = waitSel ? pinIn[4] : 1'b1;
  assign serialRxIn = rxSel ? pinIn[5] : 1'b1;
  assign serialClockIn = sckSel ? pinIn[3] : 1'b0;
endmodule // port_a_pin_function_mux

//--- rtl/port_a_map.vh
`ifndef PORT_A_MAP_VH
`define PORT_A_MAP_VH

// Register indices; byte address is four times the index
`define PA_DIR_IDX 16'hFE91
`define PA_DATA_IDX 16'hFE93
`define PA_CTRL_IDX 16'hFEDA

// Reset values of the eight-bit registers
`define PA_DIR_RESET 8'h80
`define PA_DATA_RESET 8'h80
`define PA_CTRL_RESET 8'h90

// Bits that always read as one
`define PA_DIR_READ 8'hFF
`define PA_DATA_FIXED 8'h80
`define PA_CTRL_FIXED 8'h90

// Control register field positions
`define PA_TX_EN_BIT 6
`define PA_RX_EN_BIT 5
`define PA_SCK_EN_BIT 3
`define PA_PWM3_EN_BIT 2
`define PA_PWM2_EN_BIT 1
`define PA_PWM1_EN_BIT 0

// Operating modes
`define PA_MODE1 3'h1
`define PA_MODE3 3'h3
`define PA_MODE4 3'h4
`define PA_MODE5 3'h5
`define PA_MODE6 3'h6
`define PA_MODE7 3'h7

`endif

//--- rtl/port_pin_slice.v
`timescale 1ns/1ps
// One port pin: alternate function or general-purpose path, plus read-back
module port_pin_slice (
  altUse,
  altOe,
  altOut,
  altRead,
  dirBit,
  dataBit,
  pinIn,
  pinOut,
  pinOe,
  readBit
);
  input wire altUse;
  input wire altOe;
  input wire altOut;
  input wire altRead;
  input wire dirBit;
  input wire dataBit;
  input wire pinIn;
  output wire pinOut;
  output wire pinOe;
  output wire readBit;

  // Alternate function ignores direction bit
  assign pinOe = altUse ? altOe : dirBit;
  // Stored bit reaches pin only as general output
  assign pinOut = altUse ? altOut : dataBit;
  // Input reads pin, output reads stored bit
  assign readBit = altUse ? altRead : (dirBit ? dataBit : pinIn);
endmodule // port_pin_slice

//--- tb/pin_world.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Board side of the port pins
module pin_world (
  input wire [6:0] pinOut,
  input wire [6:0] pinOe,
  input wire [6:0] ext,
  output wire [6:0] pinIn
);
  // A pin the block drives shows its own level; an undriven pin shows the outside level
  assign pinIn = (pinOe & pinOut) | (~pinOe & ext);
endmodule // pin_world

//--- tb/port_a_sva.sv
`timescale 1ns/1ps
////////////////////////////////////////
// Pin and bus relations seen at the block's ports
module port_a_sva #(
  parameter PINS = 7
) (
  input wire clock,
  input wire resetn,
  input wire wbCyc,
  input wire wbStb,
  input wire wbWe,
  input wire [17:0] wbAdr,
  input wire [31:0] wbDatR,
  input wire wbAck,
  input wire [2:0] opMode,
  input wire busCtlEnable,
  input wire waitEnable,
  input wire busAckOutN,
  input wire busReqInN,
  input wire waitInN,
  input wire [5:0] ocEnable,
  input wire [5:0] ocLevel,
  input wire [2:0] pwmOut,
  input wire [3:0] pageAddr,
  input wire [PINS-1:0] pinIn,
  input wire [PINS-1:0] pinOut,
  input wire [PINS-1:0] pinOe
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // Bus answer is one pulse, one cycle after the take
  ack_pulse_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("ack timing");
  dir_reads_a: assert property (wbCyc && wbStb && !wbWe && !wbAck && wbAdr == 18'h3FA44
    |=> wbDatR[7:0] == 8'hFF) else $error("dir read");
  no_bus7_a: assert property (opMode == 3'h7 |-> busReqInN && waitInN)
    else $error("bus in mode 7");
  bus_pins_a: assert property (opMode == 3'h4 && busCtlEnable |-> pinOe[6] && !pinOe[5]
    && pinOut[6] == busAckOutN && busReqInN == pinIn[5]) else $error("bus pins");
  wait_pin_a: assert property (opMode == 3'h4 && waitEnable |-> !pinOe[4] && waitInN == pinIn[4])
    else $error("wait pin");
  // Pin 0 in mode 4 carries either PWM or page address, never port data
  low_page_a: assert property (opMode == 3'h4 && pinOe[0] && pinOut[0] != pwmOut[0]
    |-> pinOut[0] == pageAddr[0]) else $error("page pin");
  oc_drive_a: assert property (opMode == 3'h7 |-> (pinOe[1] || !ocEnable[1])
    && (pinOe[6] || !ocEnable[5])) else $error("compare drive");
  oc_level_a: assert property (opMode == 3'h7 && ocEnable[2] && pinOut[2] != pwmOut[2]
    |-> pinOut[2] == ocLevel[2]) else $error("compare level");
endmodule // port_a_sva

bind port_a_pin_function_mux port_a_sva #(.PINS(PINS)) port_a_sva_i (.clock, .resetn, .wbCyc, .wbStb,
  .wbWe, .wbAdr, .wbDatR, .wbAck, .opMode, .busCtlEnable, .waitEnable, .busAckOutN, .busReqInN,
  .waitInN, .ocEnable, .ocLevel, .pwmOut, .pageAddr, .pinIn, .pinOut, .pinOe);

//--- tb/port_a_pin_function_mux_tb_top.sv
`timescale 1ns/1ps
`include "port_a_map.vh"
module port_a_pin_function_mux_tb_top;
  localparam logic [17:0] DIR = {`PA_DIR_IDX, 2'h0};
  localparam logic [17:0] DAT = {`PA_DATA_IDX, 2'h0};
  localparam logic [17:0] CTL = {`PA_CTRL_IDX, 2'h0};
  logic clock, resetn, wbCyc, wbStb, wbWe, wbAck, busCtlEnable, waitEnable, busAckOutN;
  logic busReqInN, waitInN, serialTxOut, serialRxIn, serialClockOut, serialClockOe, serialClockIn;
  logic [17:0] wbAdr;
  logic [3:0] wbSel, pageAddr;
  logic [31:0] wbDatW, wbDatR;
  logic [2:0] opMode, pwmOut;
  logic [5:0] ocEnable, ocLevel;
  logic [6:0] pinIn, pinOut, pinOe, ext;
  logic [7:0] q;
  int n_checks = 0;
  int n_mismatch = 0;

  port_a_pin_function_mux port_a_pin_function_mux_i (.clock, .resetn, .wbCyc, .wbStb, .wbWe, .wbAdr,
    .wbSel, .wbDatW, .wbDatR, .wbAck, .opMode, .busCtlEnable, .waitEnable, .busAckOutN, .busReqInN,
    .waitInN, .ocEnable, .ocLevel, .serialTxOut, .serialRxIn, .serialClockOut, .serialClockOe,
    .serialClockIn, .pwmOut, .pageAddr, .pinIn, .pinOut, .pinOe);
  pin_world pin_world_i (.pinOut, .pinOe, .ext, .pinIn);

  ////////////////////////////////////////
  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; held until ack is seen, bounded so a dead slave ends the run
  task automatic xfer(input logic [17:0] a, input logic we, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    wbAdr <= a;
    wbWe <= we;
    wbDatW <= {24'h0, d};
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    q = wbDatR[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t no ack", $time);
      test_done;
    end
  endtask

  task automatic rd(input logic [17:0] a, input logic [7:0] m, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(q & m, e);
  endtask

  // Pins looked at mid-cycle, after the edge's updates have landed
  task automatic pins(input logic [6:0] oe, input logic [6:0] o);
    @(negedge clock);
    chk({1'b0, pinOe}, {1'b0, oe});
    chk({1'b0, pinOut & oe}, {1'b0, o});
  endtask

  ////////////////////////////////////////
  // Main sequence: mode 7 first, then mode 4
  initial begin
    resetn = 1'b0;
    {wbCyc, wbStb, wbWe, busCtlEnable, waitEnable, busAckOutN} = 6'h0;
    {serialTxOut, serialClockOut, serialClockOe} = 3'h0;
    wbAdr = 18'h0;
    wbSel = 4'h1;
    wbDatW = 32'h0;
    opMode = 3'h7;
    pwmOut = 3'h5;
    pageAddr = 4'h8;
    ocEnable = 6'h0;
    ocLevel = 6'h2A;
    ext = 7'h4B;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    rd(DIR, 8'hFF, 8'hFF);
    rd(CTL, 8'hFF, 8'h90);
    rd(18'h00010, 8'hFF, 8'h00);
    xfer(DAT, 1'b1, 8'h55);
    pins(7'h00, 7'h00);
    rd(DAT, 8'hFF, 8'hCB);
    xfer(DIR, 1'b1, 8'h7F);
    pins(7'h7F, 7'h55);
    rd(DAT, 8'hFF, 8'hD5);
    ocEnable <= 6'h3F;
    xfer(DAT, 1'b1, 8'h00);
    pins(7'h7F, 7'h4A);
    rd(DAT, 8'hFF, 8'hCA);
    serialTxOut <= 1'b1;
    serialClockOe <= 1'b1;
    serialClockOut <= 1'b1;
    xfer(CTL, 1'b1, 8'h6F);
    pins(7'h5F, 7'h4D);
    chk({7'h0, serialRxIn}, 8'h00);
    chk({7'h0, serialClockIn}, 8'h01);
    rd(CTL, 8'hFF, 8'hFF);
    opMode <= 3'h4;
    serialTxOut <= 1'b0;
    xfer(CTL, 1'b1, 8'h00);
    xfer(DIR, 1'b1, 8'h0F);
    pins(7'h6F, 7'h48);
    xfer(DIR, 1'b1, 8'h00);
    pins(7'h60, 7'h40);
    xfer(CTL, 1'b1, 8'h47);
    pins(7'h67, 7'h05);
    xfer(DAT, 1'b1, 8'h7F);
    rd(DAT, 8'h40, 8'h00);
    busCtlEnable <= 1'b1;
    waitEnable <= 1'b1;
    busAckOutN <= 1'b1;
    pins(7'h47, 7'h45);
    chk({6'h0, busReqInN, waitInN}, 8'h00);
    chk({7'h0, serialClockIn}, 8'h00);
    rd(DAT, 8'h30, 8'h00);
    test_done;
  end
endmodule // port_a_pin_function_mux_tb_top
